// >>> verilog/fpp_defines.svh
`ifndef FPP_DEFINES_SVH
`define FPP_DEFINES_SVH
`define CLK_PERIOD_NS 20
`define T_CFG_MIN_NS 2000
`define T_CF2ST0_MAX_NS 600
`define T_STATUS_MIN_US 268
`define T_STATUS_MAX_US 1506
`define T_CF2CK_MIN_US 1506
`define T_ST2CK_MIN_US 2
`define T_CD2UM_MIN_US 175
`define T_CD2UM_MAX_US 437
`define CD2CU_CLK_PERIODS 3'd4
`define DONE_EXTRA_FALLS 3'd2
`define UCLK_INIT_PERIODS 8576
`define POR_CYCLES_DEF 1000
`define CFG_HALF_DEF 4
`define CNT_W 17
`define WCNT_W 24
`define DATA_W 16
`define REG_CTRL 4'h0
`define REG_DATA 4'h4
`define REG_STAT 4'h8
`define CTRL_START 0
`define CTRL_X16 1
`define CTRL_DECOMP 2
`define CTRL_SEC 3
`define CTRL_UCLK 4
`define STAT_IDLE 0
`define STAT_FULL 1
`define STAT_STATUS 2
`define STAT_DONE 3
`define STAT_INIT 4
`define STAT_USER 5
`define OPT_INIT_BIT 0
`define OPT_UCLK_BIT 1
`endif

// >>> verilog/fpp_pkg.sv
`include "fpp_defines.svh"
package fpp_pkg;
  typedef enum logic [6:0] {
    D_POR = 7'h01, D_REQ = 7'h02, D_HOLD = 7'h04, D_LOAD = 7'h08,
    D_DONE = 7'h10, D_INIT = 7'h20, D_USER = 7'h40
  } dev_state_t;

  typedef enum logic [6:0] {
    H_IDLE = 7'h01, H_REQ = 7'h02, H_WAIT = 7'h04, H_LOAD = 7'h08,
    H_TAIL = 7'h10, H_UCLK = 7'h20, H_USER = 7'h40
  } host_state_t;

  typedef struct packed {
    dev_state_t st;
    logic [`CNT_W-1:0] cnt;
    logic [2:0] ck_cnt;
    logic [`WCNT_W-1:0] words;
    logic first;
    logic opt_init;
    logic opt_uclk;
    logic status_low;
    logic done_low;
    logic init_low;
    logic [`DATA_W-1:0] word;
    logic word_valid;
    logic user_mode;
  } dev_regs_t;

  typedef struct packed {
    host_state_t st;
    logic [`CNT_W-1:0] cnt;
    logic [`CNT_W-1:0] cnt2;
    logic [7:0] ph;
    logic [2:0] ck_cnt;
    logic x16;
    logic decomp;
    logic sec;
    logic uclk_opt;
    logic [`DATA_W-1:0] word;
    logic full;
    logic busy;
    logic req_n;
    logic ck;
    logic uck;
    logic [`DATA_W-1:0] dout;
    logic [31:0] rdata;
  } host_regs_t;

  function automatic logic [2:0] clocks_per_word(input logic x16, input logic decomp,
                                                 input logic sec);
    if (x16) begin
      clocks_per_word = decomp ? 3'h4 : (sec ? 3'h2 : 3'h1);
    end else begin
      clocks_per_word = decomp ? 3'h2 : 3'h1;
    end
  endfunction : clocks_per_word
endpackage : fpp_pkg

// >>> verilog/fpp_link_if.sv
`timescale 1ns/1ps
`include "fpp_defines.svh"
interface fpp_link_if;
  logic config_req_n;
  logic config_clock;
  logic user_init_clock;
  logic [`DATA_W-1:0] data;
  logic status_n_o;
  logic status_n_oe;
  logic done_o;
  logic done_oe;
  logic init_done_o;
  logic init_done_oe;
  logic status_n;
  logic done;
  logic init_done;

  // The three device lines are open drain with pull-ups on the board.
  assign status_n = status_n_oe ? status_n_o : 1'b1;
  assign done = done_oe ? done_o : 1'b1;
  assign init_done = init_done_oe ? init_done_o : 1'b1;

  modport device(input config_req_n, input config_clock, input user_init_clock, input data,
                 output status_n_o, output status_n_oe, output done_o, output done_oe,
                 output init_done_o, output init_done_oe);
  modport host(output config_req_n, output config_clock, output user_init_clock,
               output data, input status_n, input done, input init_done);
endinterface : fpp_link_if

// >>> verilog/sync_edge.sv
`timescale 1ns/1ps
module sync_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_regs_t;

  sync_regs_t s_ff;
  sync_regs_t nxt_s;

  // Only the second stage and its delayed copy feed logic, never the first stage.
  always_comb begin
    nxt_s.s1 = pin;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level = s_ff.s2;
  assign rise = s_ff.s2 & ~s_ff.s3;
  assign fall = ~s_ff.s2 & s_ff.s3;
endmodule : sync_edge

// >>> verilog/fpp_device.sv
`timescale 1ns/1ps
`include "fpp_defines.svh"
module fpp_device
  import fpp_pkg::*;
#(
  parameter int POR_CYCLES = `POR_CYCLES_DEF,
  parameter int STATUS_MIN_CYC =
    (`T_STATUS_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int INIT_CYCLES =
    (`T_CD2UM_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int UCLK_INIT_PERIODS = `UCLK_INIT_PERIODS,
  parameter int IMAGE_WORDS = 64
) (
  input wire logic clk,
  input wire logic rst_b,
  fpp_link_if.device link,
  input wire logic mode_x16,
  input wire logic decompress_en,
  input wire logic security_en,
  output logic [`DATA_W-1:0] word_data,
  output logic word_valid,
  output logic user_mode,
  output logic init_opt
);
  localparam logic [`CNT_W-1:0] POR_LAST = `CNT_W'(POR_CYCLES - 1);
  localparam logic [`CNT_W-1:0] STATUS_LAST = `CNT_W'(STATUS_MIN_CYC - 1);
  localparam logic [`CNT_W-1:0] INIT_LAST = `CNT_W'(INIT_CYCLES - 1);
  localparam logic [`CNT_W-1:0] UCLK_LAST = `CNT_W'(UCLK_INIT_PERIODS - 1);
  localparam logic [`WCNT_W-1:0] WORDS_LAST = `WCNT_W'(IMAGE_WORDS - 1);

  localparam dev_regs_t RESET_REGS = '{
    st: D_POR,
    cnt: '0,
    ck_cnt: 3'h0,
    words: '0,
    first: 1'b0,
    opt_init: 1'b0,
    opt_uclk: 1'b0,
    status_low: 1'b1,
    done_low: 1'b1,
    init_low: 1'b0,
    word: '0,
    word_valid: 1'b0,
    user_mode: 1'b0
  };

  dev_regs_t s_ff;
  dev_regs_t nxt_s;

  logic req_lvl;
  logic ck_rise;
  logic ck_fall;
  logic uc_rise;
  logic [`DATA_W-1:0] data_lvl;
  logic [2:0] ratio;
  logic [`DATA_W-1:0] rx_word;

  sync_edge #(.W(1)) u_req_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(link.config_req_n),
    .level(req_lvl),
    .rise(),
    .fall()
  );

  sync_edge #(.W(1)) u_ck_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(link.config_clock),
    .level(),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  sync_edge #(.W(1)) u_uc_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(link.user_init_clock),
    .level(),
    .rise(uc_rise),
    .fall()
  );

  // Data takes the same two stages as the clock, so a word and its edge stay aligned.
  sync_edge #(.W(`DATA_W)) u_data_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(link.data),
    .level(data_lvl),
    .rise(),
    .fall()
  );

  assign ratio = clocks_per_word(mode_x16, decompress_en, security_en);
  assign rx_word = mode_x16 ? data_lvl : {8'h00, data_lvl[7:0]};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.word_valid = 1'b0;
    case (s_ff.st)
      D_POR: begin
        nxt_s.status_low = 1'b1;
        nxt_s.done_low = 1'b1;
        nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
        if (s_ff.cnt == POR_LAST) begin
          nxt_s.cnt = '0;
          if (!req_lvl) begin
            nxt_s.st = D_REQ;
          end else begin
            nxt_s.st = D_LOAD;
            nxt_s.status_low = 1'b0;
            nxt_s.words = '0;
            nxt_s.ck_cnt = 3'h0;
            nxt_s.first = 1'b1;
          end
        end
      end
      D_REQ: begin
        nxt_s.cnt = '0;
        if (req_lvl) begin
          nxt_s.st = D_HOLD;
        end
      end
      D_HOLD: begin
        // Release at the least hold time, which also meets the longest one.
        nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
        if (s_ff.cnt == STATUS_LAST) begin
          nxt_s.status_low = 1'b0;
          nxt_s.st = D_LOAD;
          nxt_s.cnt = '0;
          nxt_s.words = '0;
          nxt_s.ck_cnt = 3'h0;
          nxt_s.first = 1'b1;
        end
      end
      D_LOAD: begin
        if (ck_rise) begin
          if (s_ff.ck_cnt == ratio - 3'h1) begin
            nxt_s.ck_cnt = 3'h0;
            nxt_s.word = rx_word;
            nxt_s.word_valid = 1'b1;
            nxt_s.words = s_ff.words + `WCNT_W'(1);
            if (s_ff.first) begin
              nxt_s.first = 1'b0;
              nxt_s.opt_init = rx_word[`OPT_INIT_BIT];
              nxt_s.opt_uclk = rx_word[`OPT_UCLK_BIT];
              nxt_s.init_low = rx_word[`OPT_INIT_BIT];
            end
            if (s_ff.words == WORDS_LAST) begin
              nxt_s.done_low = 1'b0;
              nxt_s.st = D_DONE;
              nxt_s.ck_cnt = 3'h0;
            end
          end else begin
            nxt_s.ck_cnt = s_ff.ck_cnt + 3'h1;
          end
        end
      end
      D_DONE: begin
        if (ck_fall) begin
          nxt_s.ck_cnt = s_ff.ck_cnt + 3'h1;
          if (s_ff.ck_cnt == `DONE_EXTRA_FALLS - 3'h1) begin
            nxt_s.st = D_INIT;
            nxt_s.cnt = '0;
          end
        end
      end
      D_INIT: begin
        if (s_ff.opt_uclk) begin
          if (uc_rise) begin
            nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
            if (s_ff.cnt == UCLK_LAST) begin
              nxt_s.st = D_USER;
            end
          end
        end else begin
          nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
          if (s_ff.cnt == INIT_LAST) begin
            nxt_s.st = D_USER;
          end
        end
        if (nxt_s.st == D_USER) begin
          nxt_s.init_low = 1'b0;
          nxt_s.user_mode = 1'b1;
        end
      end
      D_USER: begin
        // Config clock edges are not looked at here.
        nxt_s.cnt = '0;
      end
      default: begin
        nxt_s = RESET_REGS;
      end
    endcase
    // A low request restarts from any state but power-on, within a few cycles.
    if (!req_lvl && s_ff.st != D_POR) begin
      nxt_s.st = D_REQ;
      nxt_s.status_low = 1'b1;
      nxt_s.done_low = 1'b1;
      nxt_s.init_low = 1'b0;
      nxt_s.opt_init = 1'b0;
      nxt_s.opt_uclk = 1'b0;
      nxt_s.user_mode = 1'b0;
      nxt_s.word_valid = 1'b0;
      nxt_s.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= RESET_REGS;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.status_n_o = 1'b0;
  assign link.status_n_oe = s_ff.status_low;
  assign link.done_o = 1'b0;
  assign link.done_oe = s_ff.done_low;
  assign link.init_done_o = 1'b0;
  assign link.init_done_oe = s_ff.init_low;
  assign word_data = s_ff.word;
  assign word_valid = s_ff.word_valid;
  assign user_mode = s_ff.user_mode;
  assign init_opt = s_ff.opt_init;
endmodule : fpp_device

// >>> verilog/fpp_host.sv
`timescale 1ns/1ps
`include "fpp_defines.svh"
module fpp_host
  import fpp_pkg::*;
#(
  parameter int CF2CK_CYC =
    (`T_CF2CK_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int HALF = `CFG_HALF_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  fpp_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  localparam int T_CFG_CYC = (`T_CFG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ST2CK_CYC = (`T_ST2CK_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [`CNT_W-1:0] CFG_LAST = `CNT_W'(T_CFG_CYC - 1);
  localparam logic [`CNT_W-1:0] CF2CK_LAST = `CNT_W'(CF2CK_CYC - 1);
  localparam logic [`CNT_W-1:0] ST2CK_LAST = `CNT_W'(ST2CK_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

  host_regs_t s_ff;
  host_regs_t nxt_s;
  logic [2:0] pins_lvl;
  logic wr_ctrl;
  logic start;
  logic half_end;
  logic [2:0] ratio;
  logic [31:0] stat_word;

  sync_edge #(.W(3)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin({link.init_done, link.done, link.status_n}),
    .level(pins_lvl),
    .rise(),
    .fall()
  );

  assign wr_ctrl = wr && addr == `REG_CTRL;
  assign start = wr_ctrl && wdata[`CTRL_START];
  assign half_end = s_ff.ph == HALF_LAST;
  assign ratio = clocks_per_word(s_ff.x16, s_ff.decomp, s_ff.sec);

  always_comb begin
    stat_word = 32'h0;
    stat_word[`STAT_IDLE] = s_ff.st == H_IDLE;
    stat_word[`STAT_FULL] = s_ff.full;
    stat_word[`STAT_STATUS] = pins_lvl[0];
    stat_word[`STAT_DONE] = pins_lvl[1];
    stat_word[`STAT_INIT] = pins_lvl[2];
    stat_word[`STAT_USER] = s_ff.st == H_USER;
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = 32'h0;
    nxt_s.ph = half_end ? 8'h00 : s_ff.ph + 8'h01;
    case (s_ff.st)
      H_IDLE, H_USER: begin
        if (s_ff.st == H_USER && s_ff.uclk_opt && half_end) begin
          nxt_s.uck = ~s_ff.uck;
        end
        if (start) begin
          nxt_s.st = H_REQ;
          nxt_s.req_n = 1'b0;
          nxt_s.cnt = '0;
          nxt_s.uck = 1'b0;
          nxt_s.busy = 1'b0;
        end
      end
      H_REQ: begin
        nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
        if (s_ff.cnt == CFG_LAST) begin
          nxt_s.req_n = 1'b1;
          nxt_s.st = H_WAIT;
          nxt_s.cnt = '0;
          nxt_s.cnt2 = '0;
        end
      end
      H_WAIT: begin
        if (s_ff.cnt != CF2CK_LAST) begin
          nxt_s.cnt = s_ff.cnt + `CNT_W'(1);
        end
        if (!pins_lvl[0]) begin
          nxt_s.cnt2 = '0;
        end else if (s_ff.cnt2 != ST2CK_LAST) begin
          nxt_s.cnt2 = s_ff.cnt2 + `CNT_W'(1);
        end
        if (s_ff.cnt == CF2CK_LAST && s_ff.cnt2 == ST2CK_LAST) begin
          nxt_s.st = H_LOAD;
        end
      end
      H_LOAD: begin
        if (s_ff.busy) begin
          if (half_end) begin
            nxt_s.ck = ~s_ff.ck;
            if (s_ff.ck) begin
              nxt_s.ck_cnt = s_ff.ck_cnt + 3'h1;
              if (s_ff.ck_cnt == ratio - 3'h1) begin
                nxt_s.busy = 1'b0;
                nxt_s.full = 1'b0;
              end
            end
          end
        end else if (pins_lvl[1]) begin
          nxt_s.st = H_TAIL;
          nxt_s.ck_cnt = 3'h0;
          nxt_s.ph = 8'h00;
        end else if (s_ff.full) begin
          // Data leads the first rising edge by a full half period of setup.
          nxt_s.dout = s_ff.x16 ? s_ff.word : {8'h00, s_ff.word[7:0]};
          nxt_s.busy = 1'b1;
          nxt_s.ph = 8'h00;
          nxt_s.ck_cnt = 3'h0;
        end
      end
      H_TAIL, H_UCLK: begin
        if (half_end) begin
          nxt_s.ck = ~s_ff.ck;
          if (s_ff.ck) begin
            nxt_s.ck_cnt = s_ff.ck_cnt + 3'h1;
            if (s_ff.st == H_TAIL && s_ff.ck_cnt == `DONE_EXTRA_FALLS - 3'h1) begin
              nxt_s.ck_cnt = 3'h0;
              nxt_s.st = s_ff.uclk_opt ? H_UCLK : H_USER;
            end
            if (s_ff.st == H_UCLK && s_ff.ck_cnt == `CD2CU_CLK_PERIODS - 3'h1) begin
              nxt_s.st = H_USER;
            end
          end
        end
      end
      default: begin
        nxt_s.st = H_IDLE;
        nxt_s.req_n = 1'b1;
      end
    endcase
    // After the last fall the clock rests low, which the device ignores.
    if (wr_ctrl) begin
      nxt_s.x16 = wdata[`CTRL_X16];
      nxt_s.decomp = wdata[`CTRL_DECOMP];
      nxt_s.sec = wdata[`CTRL_SEC];
      nxt_s.uclk_opt = wdata[`CTRL_UCLK];
    end
    // A write in the cycle the word is consumed wins over the clear.
    if (wr && addr == `REG_DATA) begin
      nxt_s.word = wdata[`DATA_W-1:0];
      nxt_s.full = 1'b1;
    end
    if (rd) begin
      case (addr)
        `REG_CTRL: nxt_s.rdata = {27'h0, s_ff.uclk_opt, s_ff.sec, s_ff.decomp, s_ff.x16, 1'b0};
        `REG_DATA: nxt_s.rdata = {16'h0, s_ff.word};
        `REG_STAT: nxt_s.rdata = stat_word;
        default: nxt_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '{st: H_IDLE, req_n: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.config_req_n = s_ff.req_n;
  assign link.config_clock = s_ff.ck;
  assign link.user_init_clock = s_ff.uck;
  assign link.data = s_ff.dout;
  assign rdata = s_ff.rdata;
endmodule : fpp_host

// >>> sim/fpp_link_properties.sv
`timescale 1ns/1ps
module fpp_link_properties #(
  parameter int POR_CYCLES = 20,
  parameter int STATUS_MIN_CYC = 50,
  parameter int STATUS_MAX_CYC = 60,
  parameter int CF2CK_CYC = 60,
  parameter int IMAGE_WORDS = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic config_req_n,
  input wire logic config_clock,
  input wire logic user_init_clock,
  input wire logic status_n,
  input wire logic done,
  input wire logic init_done
);
  int por_ff, req_lo_ff, rise_ff, st_hi_ff, ck_ff, fall_ff;
  logic seen_ff, first_ff, ck_q_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      por_ff <= 0;
      req_lo_ff <= 0;
      rise_ff <= 0;
      st_hi_ff <= 0;
      ck_ff <= 0;
      fall_ff <= 0;
      seen_ff <= 1'b0;
      first_ff <= 1'b0;
      ck_q_ff <= 1'b0;
    end else begin
      por_ff <= por_ff + 1;
      req_lo_ff <= config_req_n ? 0 : req_lo_ff + 1;
      rise_ff <= config_req_n ? rise_ff + 1 : 0;
      st_hi_ff <= status_n ? st_hi_ff + 1 : 0;
      ck_ff <= !config_req_n ? 0 : ck_ff + int'(config_clock && !ck_q_ff);
      fall_ff <= !done ? 0 : fall_ff + int'(!config_clock && ck_q_ff);
      seen_ff <= seen_ff | !config_req_n;
      first_ff <= !config_req_n ? 1'b1 : (config_clock && !ck_q_ff ? 1'b0 : first_ff);
      ck_q_ff <= config_clock;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_POR_STATUS: assert property (por_ff < POR_CYCLES |-> !status_n)
    else $error("status released during power-on delay");
  AST_REQ_PULLS_LOW: assert property ($fell(config_req_n) |->
      ##[1:30] (!status_n && !done))
    else $error("status or done not low after request");
  AST_REQ_HOLDS_LOW: assert property ((!config_req_n) [*8] |-> (!status_n && !done))
    else $error("request low did not start a new cycle");
  AST_REQ_WIDTH: assert property ($rose(config_req_n) |-> req_lo_ff >= 100)
    else $error("request pulse too short");
  AST_STATUS_WIDTH: assert property ($rose(status_n) && seen_ff |->
      (rise_ff >= STATUS_MIN_CYC && rise_ff <= STATUS_MAX_CYC))
    else $error("status low time out of range");
  AST_FIRST_CLOCK: assert property (config_clock && !ck_q_ff && first_ff |->
      (rise_ff >= CF2CK_CYC && st_hi_ff >= 100))
    else $error("first config clock too early");
  AST_DONE_AFTER_DATA: assert property ($rose(done) |-> ck_ff >= IMAGE_WORDS)
    else $error("done rose before all data");
  AST_TWO_FALLS: assert property ($rose(done) |->
      ##[1:40] $fell(config_clock) ##[1:20] $fell(config_clock))
    else $error("missing falling edges after done");
  AST_INIT_AFTER_DONE: assert property ($rose(init_done) |-> done)
    else $error("init done released before done");
  AST_INIT_LOW_LOAD: assert property ($fell(init_done) |-> (!done && status_n))
    else $error("init done pulled low outside loading");
  AST_UCLK_DELAY: assert property ($rose(user_init_clock) |-> (done && fall_ff >= 4))
    else $error("user clock started too early");
endmodule : fpp_link_properties

// >>> sim/fast_passive_parallel_config_port_tb_top.sv
`timescale 1ns/1ps
`include "fpp_defines.svh"
module fast_passive_parallel_config_port_tb_top;
  localparam int IMAGE_WORDS = 8;
  localparam int INIT_CYCLES = 40;
  localparam int UCLK_PERIODS = 10;
  localparam int HALF = 4;
  localparam int POR_CYCLES = 20;
  localparam int STATUS_MIN_CYC = 50;
  localparam int STATUS_MAX_CYC = 60;
  localparam int CF2CK_CYC = 60;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic mode_x16 = 1'b0;
  logic decompress_en = 1'b0;
  logic security_en = 1'b0;
  logic [15:0] word_data;
  logic word_valid, user_mode, init_opt;
  logic ck_q = 1'b0;
  logic done_q = 1'b0;
  logic um_q = 1'b0;
  logic [31:0] rd_val;
  logic [15:0] got_q[$];
  int n_mismatch = 0, n_checks = 0, cyc = 0, n_words = 0, ck_rises = 0, done_at = 0, um_at = 0;

  always #10 clk = ~clk;

  fpp_link_if fpp_link_if_i();
  fpp_host #(.CF2CK_CYC(CF2CK_CYC), .HALF(HALF)) fpp_host_i(.clk(clk), .rst_b(rst_b),
    .link(fpp_link_if_i.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  fpp_device #(.POR_CYCLES(POR_CYCLES), .STATUS_MIN_CYC(STATUS_MIN_CYC),
    .INIT_CYCLES(INIT_CYCLES), .UCLK_INIT_PERIODS(UCLK_PERIODS),
    .IMAGE_WORDS(IMAGE_WORDS)) fpp_device_i(.clk(clk),
    .rst_b(rst_b), .link(fpp_link_if_i.device), .mode_x16(mode_x16),
    .decompress_en(decompress_en), .security_en(security_en), .word_data(word_data),
    .word_valid(word_valid), .user_mode(user_mode), .init_opt(init_opt));
  fpp_link_properties #(.POR_CYCLES(POR_CYCLES), .STATUS_MIN_CYC(STATUS_MIN_CYC),
    .STATUS_MAX_CYC(STATUS_MAX_CYC), .CF2CK_CYC(CF2CK_CYC), .IMAGE_WORDS(IMAGE_WORDS))
    fpp_link_properties_i(.clk(clk), .rst_b(rst_b),
    .config_req_n(fpp_link_if_i.config_req_n), .config_clock(fpp_link_if_i.config_clock),
    .user_init_clock(fpp_link_if_i.user_init_clock), .status_n(fpp_link_if_i.status_n),
    .done(fpp_link_if_i.done), .init_done(fpp_link_if_i.init_done));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe, so it is taken just after that edge.
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wait_stat(input int b, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd_reg(`REG_STAT, rd_val);
      if (rd_val[b] === v) break;
    end
    chk("stat_bit", {31'h0, rd_val[b]}, {31'h0, v});
  endtask : wait_stat

  initial begin
    wait (cyc == 30000);
    n_mismatch++;
    stop_test();
  end

  // Clock rises are only counted while done is low, so the extra edges are excluded; words are counted on every word_valid.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ck_q <= fpp_link_if_i.config_clock;
    done_q <= fpp_link_if_i.done;
    um_q <= user_mode;
    if (fpp_link_if_i.config_clock && !ck_q && !fpp_link_if_i.done) ck_rises <= ck_rises + 1;
    if (word_valid) begin
      got_q.push_back(word_data);
      n_words <= n_words + 1;
      if (n_words < IMAGE_WORDS - 1) chk("done_in_load", fpp_link_if_i.done, 32'h0);
      if (!mode_x16) chk("data_upper", fpp_link_if_i.data[15:8], 32'h0);
    end
    if (!fpp_link_if_i.config_req_n) begin
      ck_rises <= 0;
      n_words <= 0;
    end
    if (fpp_link_if_i.done && !done_q) done_at <= cyc;
    if (user_mode && !um_q) um_at <= cyc;
  end

  task automatic run_cfg(input logic [4:0] ctrl, input logic [1:0] opt);
    logic [31:0] wd;
    int cpw;
    int dt;
    cpw = ctrl[2] ? (ctrl[1] ? 4 : 2) : ((ctrl[1] && ctrl[3]) ? 2 : 1);
    @(posedge clk);
    mode_x16 <= ctrl[1];
    decompress_en <= ctrl[2];
    security_en <= ctrl[3];
    got_q.delete();
    wr_reg(`REG_CTRL, {27'h0, ctrl});
    rd_reg(`REG_CTRL, rd_val);
    chk("ctrl_rd", rd_val[4:0], {ctrl[4:1], 1'b0});
    for (int w = 0; w < IMAGE_WORDS; w++) begin
      wait_stat(`STAT_FULL, 1'b0, 300);
      wr_reg(`REG_DATA, (w == 0) ? {30'h0, opt} : 32'h5a00 + w);
    end
    wait_stat(`STAT_USER, 1'b1, 300);
    for (int i = 0; i < 500 && !user_mode; i++) @(posedge clk);
    #1;
    chk("words", n_words, IMAGE_WORDS);
    chk("clock_rises", ck_rises, IMAGE_WORDS * cpw);
    for (int w = 0; w < IMAGE_WORDS; w++) begin
      wd = (w == 0) ? {30'h0, opt} : 32'h5a00 + w;
      chk("word", got_q[w], ctrl[1] ? wd[15:0] : {8'h00, wd[7:0]});
    end
    chk("init_opt", init_opt, opt[0]);
    chk("user_mode", user_mode, 32'h1);
    chk("pins_high", {fpp_link_if_i.status_n, fpp_link_if_i.done,
      fpp_link_if_i.init_done}, 32'h7);
    rd_reg(`REG_STAT, rd_val);
    chk("stat_user", rd_val[5:0], 32'h3c);
    rd_reg(`REG_DATA, rd_val);
    chk("data_rd", rd_val, 32'h5a00 + IMAGE_WORDS - 1);
    dt = um_at - done_at;
    if (opt[1]) chk("uclk_init", dt >= UCLK_PERIODS * 2 * HALF, 32'h1);
    else chk("init_time", dt >= INIT_CYCLES && dt <= INIT_CYCLES * 437 / 175, 32'h1);
  endtask : run_cfg

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(4'hc, 32'hffff_ffff);
    rd_reg(4'hc, rd_val);
    chk("unmapped", rd_val, 32'h0);
    wait_stat(`STAT_IDLE, 1'b1, 4);
    wait_stat(`STAT_STATUS, 1'b1, 40);
    // Every width, decompression and security mix, user clock init on two of them.
    for (int i = 0; i < 8; i++) begin
      run_cfg({(i == 3 || i == 6), i[2], i[1], i[0], 1'b1},
        {(i == 3 || i == 6), i[0] ^ i[1]});
    end
    stop_test();
  end
endmodule : fast_passive_parallel_config_port_tb_top
